/* eep_defs.vh */
// Register map, field positions, reset values and timing constants of the EEPROM controller
`ifndef EEP_DEFS_VH
`define EEP_DEFS_VH
// ----------------------------------------
// Register offsets (APB byte addresses)
// ----------------------------------------
`define EEP_OFF_CTRL 13'h0000
`define EEP_OFF_ACR 13'h0004
`define EEP_OFF_DIVH 13'h0008
`define EEP_OFF_DIVL 13'h000C
// Array window: byte address = base + 4 * target index
`define EEP_ARR_SEL_BIT 12
`define EEP_ARR_BYTES 10'h200
`define EEP_NV_PROT 10'h200
`define EEP_NV_DIVH 10'h201
`define EEP_NV_DIVL 10'h202
`define EEP_TGT_COUNT 10'h203
// CPU addresses of the array and of the secured range
`define EEP_CPU_BASE 16'h0600
`define EEP_SEC_LO 16'h06F0
`define EEP_SEC_HI 16'h06FF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EEP_CTRL_SPARE 7
`define EEP_CTRL_OFF 6
`define EEP_CTRL_MODE_HI 5
`define EEP_CTRL_MODE_LO 4
`define EEP_CTRL_LAT 3
`define EEP_CTRL_AUTO 2
`define EEP_CTRL_PGM 0
`define EEP_ACR_SPARE_HI 7
`define EEP_ACR_SPARE_LO 5
`define EEP_ACR_SEC 4
`define EEP_DIVH_LOCKDIS 7
// ----------------------------------------
// Modes, reset and factory values
// ----------------------------------------
`define EEP_MODE_BPROG 2'h0
`define EEP_MODE_BERASE 2'h1
`define EEP_MODE_BLOCK 2'h2
`define EEP_MODE_BULK 2'h3
`define EEP_ACR_RST 8'h1F
`define EEP_ERASED 8'hFF
`define EEP_NV_PROT_FACTORY 8'hF0
// ----------------------------------------
// Timing
// ----------------------------------------
`define EEP_TICK_US 35
`define EEP_PROG_TICKS 8'h0A
`define EEP_BERASE_TICKS 8'h0A
`define EEP_BLOCK_TICKS 8'h0A
`define EEP_BULK_TICKS 8'h0A
`endif

/* eep_ctrl.v */
// EEPROM program/erase controller with APB register slave and byte array
`timescale 1ns/1ps
`default_nettype none
`include "eep_defs.vh"
module eep_ctrl
#(
    parameter TW = 8,
    parameter [TW-1:0] PROG_TICKS = `EEP_PROG_TICKS,
    parameter [TW-1:0] BERASE_TICKS = `EEP_BERASE_TICKS,
    parameter [TW-1:0] BLOCK_TICKS = `EEP_BLOCK_TICKS,
    parameter [TW-1:0] BULK_TICKS = `EEP_BULK_TICKS
)
(
    // Clock and reset
    input wire clock,
    input wire reset,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [12:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // System
    input wire stop_mode,
    input wire ref_select,
    input wire crystal_reference_clock,
    // Status
    output wire charge_pump_on,
    output wire seq_busy,
    output wire array_powered
);

// ----------------------------------------
// Declarations
// ----------------------------------------
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_RUN = 2'h1;
localparam [1:0] ST_HALT = 2'h2;
localparam [1:0] ST_HOLD = 2'h3;
// Reset image of the configuration register, sliced below for the security and protect fields
localparam [7:0] ACR_RST = `EEP_ACR_RST;

reg [7:0] mem [0:514];
reg ctrl_spare_q;
reg power_down_q;
reg [1:0] erase_mode_q;
reg bus_latch_enable_q;
reg auto_q;
reg program_erase_enable_q;
reg [2:0] acr_spare_q;
reg security_lock_q;
reg [3:0] block_protect_q;
reg [10:0] timebase_divisor_q;
reg divider_lock_disable_q;
reg [9:0] lat_tgt_q;
reg [7:0] lat_data_q;
reg lat_valid_q;
reg load_q;
reg [1:0] state_q;
reg [TW-1:0] tick_cnt_q;
reg [10:0] div_cnt_q;
reg tick_q;
reg restart_q;
reg op_ok_q;
reg ref_s1_q;
reg ref_s2_q;
reg ref_s3_q;
reg [7:0] prdata_q;
reg [7:0] rd_d;
reg [TW-1:0] limit;
integer i;
integer k;

// ----------------------------------------
// APB decode
// ----------------------------------------
wire setup = psel & ~penable;
wire acc = psel & penable;
wire wr = acc & pwrite;
wire rd = acc & ~pwrite;
wire [9:0] tgt = paddr[11:2];
wire is_arr = paddr[`EEP_ARR_SEL_BIT] & (paddr[1:0] == 2'h0) & (tgt < `EEP_TGT_COUNT);
wire hit_ctrl = (paddr == `EEP_OFF_CTRL);
wire hit_acr = (paddr == `EEP_OFF_ACR);
wire hit_divh = (paddr == `EEP_OFF_DIVH);
wire hit_divl = (paddr == `EEP_OFF_DIVL);
wire mapped = hit_ctrl | hit_acr | hit_divh | hit_divl | is_arr;
// Array access is refused while a restarted sequence is still running
wire arr_block = is_arr & restart_q;

// Zero wait states; errors only for holes and blocked array access
assign pready = 1'b1;
assign pslverr = acc & (~mapped | arr_block);
assign prdata = {24'h000000, prdata_q};

// ----------------------------------------
// Permission check on the latched target
// ----------------------------------------
wire tgt_arr = ~lat_tgt_q[9];
wire [1:0] blk = lat_tgt_q[8:7];
wire [15:0] cpu_addr = `EEP_CPU_BASE + {6'h00, lat_tgt_q};
wire in_sec = (cpu_addr >= `EEP_SEC_LO) & (cpu_addr <= `EEP_SEC_HI);
wire sec_on = ~security_lock_q;
wire arr_ok = ~block_protect_q[blk]
    & ~(sec_on & (erase_mode_q[1] | in_sec))
    & ((erase_mode_q != `EEP_MODE_BULK) | (block_protect_q == 4'h0));
// Erasing the protection byte while secured would undo security
wire nvp_ok = ~(sec_on & (erase_mode_q != `EEP_MODE_BPROG));
wire nvd_ok = divider_lock_disable_q;
wire allowed = ~power_down_q & (tgt_arr ? arr_ok :
    ((lat_tgt_q == `EEP_NV_PROT) ? nvp_ok : nvd_ok));

// ----------------------------------------
// Sequencer terms
// ----------------------------------------
always @*
begin
    case (erase_mode_q)
        `EEP_MODE_BPROG: limit = PROG_TICKS;
        `EEP_MODE_BERASE: limit = BERASE_TICKS;
        `EEP_MODE_BLOCK: limit = BLOCK_TICKS;
        default: limit = BULK_TICKS;
    endcase
end

wire [TW-1:0] cnt_next = tick_cnt_q + {{(TW-1){1'b0}}, 1'b1};
wire run_end = (state_q == ST_RUN) & tick_q & (cnt_next >= limit) & ~stop_mode;
wire commit = run_end & op_ok_q & program_erase_enable_q;
wire auto_clear = run_end & auto_q;
wire lat_ok = bus_latch_enable_q & lat_valid_q;

assign charge_pump_on = (state_q == ST_RUN);
assign seq_busy = (state_q != ST_IDLE);
assign array_powered = ~power_down_q;

// ----------------------------------------
// Factory contents and array updates
// ----------------------------------------
// Simulation and FPGA start state of the nonvolatile cells
initial
begin
    for (k = 0; k < 515; k = k + 1)
        mem[k] = `EEP_ERASED;
    mem[`EEP_NV_PROT] = `EEP_NV_PROT_FACTORY;
end

// Cells keep their contents through reset, as nonvolatile storage does
always @(posedge clock)
begin
    if (commit)
    begin
        if (~tgt_arr || erase_mode_q == `EEP_MODE_BPROG)
            mem[lat_tgt_q] <= (erase_mode_q == `EEP_MODE_BPROG) ?
                (mem[lat_tgt_q] & lat_data_q) : `EEP_ERASED;
        else if (erase_mode_q == `EEP_MODE_BERASE)
            mem[lat_tgt_q] <= `EEP_ERASED;
        else
            for (i = 0; i < 512; i = i + 1)
                if (erase_mode_q == `EEP_MODE_BULK || i[8:7] == blk)
                    mem[i] <= `EEP_ERASED;
    end
end

// ----------------------------------------
// Read data, sampled in the setup phase
// ----------------------------------------
always @*
begin
    rd_d = 8'h00;
    if (hit_ctrl)
        rd_d = {ctrl_spare_q, power_down_q, erase_mode_q, bus_latch_enable_q, auto_q,
            1'b0, program_erase_enable_q};
    else if (hit_acr)
        rd_d = {acr_spare_q, security_lock_q, block_protect_q};
    else if (hit_divh)
        rd_d = {divider_lock_disable_q, 4'h0, timebase_divisor_q[10:8]};
    else if (hit_divl)
        rd_d = timebase_divisor_q[7:0];
    else if (is_arr && !power_down_q && !restart_q)
        rd_d = bus_latch_enable_q ? lat_data_q : mem[tgt];
end

always @(posedge clock or posedge reset)
begin
    if (reset)
        prdata_q <= 8'h00;
    else if (setup)
        prdata_q <= rd_d;
end

// ----------------------------------------
// Control register
// ----------------------------------------
always @(posedge clock or posedge reset)
begin
    if (reset)
    begin
        ctrl_spare_q <= 1'b0;
        power_down_q <= 1'b0;
        erase_mode_q <= 2'h0;
        bus_latch_enable_q <= 1'b0;
        auto_q <= 1'b0;
        program_erase_enable_q <= 1'b0;
    end
    else
    begin
        if (wr && hit_ctrl)
        begin
            ctrl_spare_q <= pwdata[`EEP_CTRL_SPARE];
            power_down_q <= pwdata[`EEP_CTRL_OFF];
            erase_mode_q <= pwdata[`EEP_CTRL_MODE_HI:`EEP_CTRL_MODE_LO];
            auto_q <= pwdata[`EEP_CTRL_AUTO];
            // Latch holds while enable was set, so voltage decays first
            bus_latch_enable_q <= pwdata[`EEP_CTRL_LAT] | program_erase_enable_q;
            // Enable only after a valid address sits in the latch
            program_erase_enable_q <= pwdata[`EEP_CTRL_PGM] & lat_ok & ~auto_clear;
        end
        else if (auto_clear)
            program_erase_enable_q <= 1'b0;
    end
end

// ----------------------------------------
// Address and data latch
// ----------------------------------------
always @(posedge clock or posedge reset)
begin
    if (reset)
    begin
        lat_tgt_q <= 10'h000;
        lat_data_q <= 8'h00;
        lat_valid_q <= 1'b0;
    end
    else if (!bus_latch_enable_q)
        lat_valid_q <= 1'b0;
    else if (acc && is_arr && !restart_q)
    begin
        // Later accesses overwrite the earlier target
        lat_tgt_q <= tgt;
        lat_valid_q <= 1'b1;
        if (pwrite)
            lat_data_q <= pwdata[7:0];
    end
end

// ----------------------------------------
// Configuration and divisor registers
// ----------------------------------------
// Reload happens one edge after release; the cells are not reset-sensitive
always @(posedge clock or posedge reset)
begin
    if (reset)
    begin
        load_q <= 1'b1;
        acr_spare_q <= 3'h0;
        security_lock_q <= ACR_RST[`EEP_ACR_SEC];
        block_protect_q <= ACR_RST[3:0];
        timebase_divisor_q <= 11'h000;
        divider_lock_disable_q <= 1'b0;
    end
    else if (load_q)
    begin
        load_q <= 1'b0;
        acr_spare_q <= mem[`EEP_NV_PROT][`EEP_ACR_SPARE_HI:`EEP_ACR_SPARE_LO];
        security_lock_q <= mem[`EEP_NV_PROT][`EEP_ACR_SEC];
        block_protect_q <= mem[`EEP_NV_PROT][3:0];
        timebase_divisor_q <= {mem[`EEP_NV_DIVH][2:0], mem[`EEP_NV_DIVL]};
        divider_lock_disable_q <= mem[`EEP_NV_DIVH][`EEP_DIVH_LOCKDIS];
    end
    else
    begin
        if (wr && hit_acr)
            acr_spare_q <= pwdata[`EEP_ACR_SPARE_HI:`EEP_ACR_SPARE_LO];
        if (wr && hit_divh && !bus_latch_enable_q && divider_lock_disable_q)
        begin
            divider_lock_disable_q <= pwdata[`EEP_DIVH_LOCKDIS];
            timebase_divisor_q[10:8] <= pwdata[2:0];
        end
        if (wr && hit_divl && !bus_latch_enable_q && divider_lock_disable_q)
            timebase_divisor_q[7:0] <= pwdata[7:0];
    end
end

// ----------------------------------------
// Timebase tick
// ----------------------------------------
// Reference pin crosses into the bus clock before edge detection
always @(posedge clock or posedge reset)
begin
    if (reset)
    begin
        ref_s1_q <= 1'b0;
        ref_s2_q <= 1'b0;
        ref_s3_q <= 1'b0;
    end
    else
    begin
        ref_s1_q <= crystal_reference_clock;
        ref_s2_q <= ref_s1_q;
        ref_s3_q <= ref_s2_q;
    end
end

// Reference must be well below half the bus clock to be seen
wire src_pulse = ref_select ? (ref_s2_q & ~ref_s3_q) : 1'b1;

always @(posedge clock or posedge reset)
begin
    if (reset)
    begin
        div_cnt_q <= 11'h000;
        tick_q <= 1'b0;
    end
    else
    begin
        tick_q <= 1'b0;
        if (timebase_divisor_q == 11'h000)
            div_cnt_q <= 11'h000;
        else if (src_pulse)
        begin
            if (div_cnt_q >= timebase_divisor_q - 11'h001)
            begin
                div_cnt_q <= 11'h000;
                tick_q <= 1'b1;
            end
            else
                div_cnt_q <= div_cnt_q + 11'h001;
        end
    end
end

// ----------------------------------------
// Program/erase sequencer
// ----------------------------------------
// Runs on the bus clock only, so core wait does not disturb it
always @(posedge clock or posedge reset)
begin
    if (reset)
    begin
        state_q <= ST_IDLE;
        tick_cnt_q <= {TW{1'b0}};
        restart_q <= 1'b0;
        op_ok_q <= 1'b0;
    end
    else
    begin
        case (state_q)
            ST_IDLE:
            begin
                if (program_erase_enable_q && lat_ok && !stop_mode)
                begin
                    state_q <= ST_RUN;
                    tick_cnt_q <= {TW{1'b0}};
                    op_ok_q <= allowed;
                end
            end
            ST_RUN:
            begin
                if (!program_erase_enable_q || power_down_q)
                begin
                    state_q <= ST_IDLE;
                    restart_q <= 1'b0;
                end
                else if (stop_mode)
                    state_q <= ST_HALT;
                else if (run_end)
                begin
                    state_q <= auto_q ? ST_IDLE : ST_HOLD;
                    restart_q <= 1'b0;
                end
                else if (tick_q)
                    tick_cnt_q <= cnt_next;
            end
            ST_HALT:
            begin
                if (!program_erase_enable_q)
                begin
                    // Abandoned after a halt: array access must not stay blocked
                    state_q <= ST_IDLE;
                    restart_q <= 1'b0;
                end
                else if (!stop_mode)
                begin
                    // Whole pulse is repeated after wake-up
                    state_q <= ST_RUN;
                    tick_cnt_q <= {TW{1'b0}};
                    restart_q <= 1'b1;
                end
            end
            ST_HOLD:
            begin
                if (!program_erase_enable_q)
                    state_q <= ST_IDLE;
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

endmodule // eep_ctrl
`default_nettype wire

/* eep_ctrl_chk.sv */
// Port-level checks for the EEPROM controller
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl_chk
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [12:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // System and status
    input wire logic stop_mode,
    input wire logic charge_pump_on,
    input wire logic seq_busy,
    input wire logic array_powered
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Control write asking for the enable with the latch held
    wire wr_go = psel && penable && pwrite && paddr == 13'h0000 && pwdata[3] && pwdata[0];
    sequence ctrl_wr_s;
        psel && penable && pwrite && paddr == 13'h0000;
    endsequence
    sequence arr_rd_s;
        psel && !penable && !pwrite && paddr[12] && paddr < 13'h180C;
    endsequence
    pready_a: assert property (psel && penable |-> pready)
        else $error("access cycle not answered");
    rd_upper_a: assert property (psel && !penable |=> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rd_stand_a: assert property (psel && penable |=> $stable(prdata))
        else $error("read data moved after access");
    power_bit_a: assert property (ctrl_wr_s |=> array_powered == !$past(pwdata[6]))
        else $error("power state does not follow control write");
    power_read_a: assert property (arr_rd_s ##0 !array_powered |=> prdata == 32'h0)
        else $error("powered-down array returned data");
    pump_busy_a: assert property (charge_pump_on |-> seq_busy)
        else $error("pump on with sequencer idle");
    start_cause_a: assert property ($rose(seq_busy) |-> $past(wr_go) || $past(wr_go, 2))
        else $error("sequence started without enable request");
    stop_halt_a: assert property (stop_mode |=> !charge_pump_on)
        else $error("pump still on in stop");
    stop_keep_a: assert property (charge_pump_on && stop_mode |=> seq_busy)
        else $error("stop dropped a running sequence");
endmodule // eep_ctrl_chk
`default_nettype wire

/* tb_eep_ctrl.sv */
// Self-checking bench for the EEPROM controller over APB
`timescale 1ns/1ps
`default_nettype none
module tb_eep_ctrl;
    // ----
    // Signals
    // ----
    logic clock;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic [12:0] paddr;
    logic [31:0] pwdata;
    logic stop_mode;
    logic ref_select;
    logic [2:0] ref_cnt;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire charge_pump_on;
    wire seq_busy;
    wire array_powered;
    logic [31:0] q;
    logic slv;
    int err_total;
    int num_checks;

    // Short tick counts keep each operation to a few dozen cycles
    eep_ctrl #(.PROG_TICKS(8'h02), .BERASE_TICKS(8'h02), .BLOCK_TICKS(8'h02),
        .BULK_TICKS(8'h02)) eep_ctrl_inst
    (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .ref_select(ref_select), .crystal_reference_clock(ref_cnt[2]),
        .charge_pump_on(charge_pump_on), .seq_busy(seq_busy), .array_powered(array_powered)
    );

    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Slow reference: one rising edge every eight bus clocks
    always @(posedge clock or posedge reset)
    begin
        if (reset)
            ref_cnt <= 3'h0;
        else
            ref_cnt <= ref_cnt + 3'h1;
    end

    // ----
    // Tasks
    // ----
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer; answer taken at the edge where pready is sampled high
    task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rc(input logic [12:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        cmp(q, {24'h0, e});
    endtask

    function automatic logic [12:0] ar(input logic [9:0] i);
        return 13'h1000 + {1'b0, i, 2'b00};
    endfunction

    // Bounded wait for the sequencer to go idle
    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (seq_busy !== 1'b0 && n < 400);
        if (seq_busy !== 1'b0)
            cmp(32'h1, 32'h0);
        @(posedge clock);
    endtask

    // Latch, write target, enable with auto end, then drop the latch
    task automatic op(input logic [1:0] m, input logic [9:0] i, input logic [7:0] d);
        wr(13'h0000, {26'h0, m, 4'hC});
        wr(ar(i), {24'h0, d});
        wr(13'h0000, {26'h0, m, 4'hD});
        wait_idle;
        wr(13'h0000, 32'h0);
    endtask

    task automatic do_reset;
        reset <= 1'b1;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // Divisor of 4 bus clocks per tick
    task automatic set_div;
        wr(13'h0008, 32'h80);
        wr(13'h000C, 32'h04);
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the whole run needs under a thousand cycles
    initial
    begin
        #300000;
        err_total++;
        conclude;
    end

    // ----
    // Scenarios
    // ----
    initial
    begin
        err_total = 0;
        num_checks = 0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 13'h0000;
        pwdata <= 32'h0;
        stop_mode <= 1'b0;
        ref_select <= 1'b0;
        do_reset;
        rc(13'h0000, 8'h00);
        rc(13'h0004, 8'hF0);
        rc(13'h0008, 8'h87);
        rc(13'h000C, 8'hFF);
        xfer(1'b0, 13'h0010, 32'h0);
        cmp({31'h0, slv}, 32'h1);
        wr(13'h0000, 32'h80);
        rc(13'h0000, 8'h80);
        wr(13'h0004, 32'hE5);
        rc(13'h0004, 8'hF0);
        wr(13'h0004, 32'h00);
        rc(13'h0004, 8'h10);
        wr(13'h0000, 32'h40);
        cmp({31'h0, array_powered}, 32'h0);
        rc(ar(10'h005), 8'h00);
        wr(13'h0000, 32'h01);
        rc(13'h0000, 8'h00);
        set_div;
        rc(13'h000C, 8'h04);
        wr(13'h0000, 32'h08);
        wr(13'h0000, 32'h09);
        rc(13'h0000, 8'h08);
        wr(13'h000C, 32'h07);
        rc(13'h000C, 8'h04);
        // Second write replaces the first, a read moves the target
        wr(13'h0000, 32'h0C);
        wr(ar(10'h008), 32'h33);
        wr(ar(10'h009), 32'hA5);
        rc(ar(10'h00A), 8'hA5);
        wr(13'h0000, 32'h0D);
        wait_idle;
        rc(13'h0000, 8'h0C);
        wr(13'h0000, 32'h00);
        rc(ar(10'h00A), 8'hA5);
        rc(ar(10'h009), 8'hFF);
        // Manual mode: latch held while enabled, and still held after the write that clears the enable
        wr(13'h0000, 32'h08);
        wr(ar(10'h00B), 32'h0F);
        wr(13'h0000, 32'h09);
        wr(13'h0000, 32'h01);
        rc(13'h0000, 8'h09);
        wr(13'h0000, 32'h00);
        rc(13'h0000, 8'h08);
        wr(13'h0000, 32'h00);
        for (int i = 1; i < 4; i++)
        begin
            op(2'h0, 10'h003, 8'h00);
            rc(ar(10'h003), 8'h00);
            op(2'(i), 10'(3 + (i - 1) * 97), 8'h00);
            rc(ar(10'h003), 8'hFF);
        end
        // Reference-clock timebase: ticks far slower than the bus path
        ref_select <= 1'b1;
        wr(13'h0000, 32'h0C);
        wr(ar(10'h010), 32'h5A);
        wr(13'h0000, 32'h0D);
        repeat (12) @(posedge clock);
        cmp({31'h0, seq_busy}, 32'h1);
        wait_idle;
        wr(13'h0000, 32'h00);
        ref_select <= 1'b0;
        rc(ar(10'h010), 8'h5A);
        // Stop during a running program halts and later restarts it
        wr(13'h0000, 32'h0C);
        wr(ar(10'h014), 32'h3C);
        wr(13'h0000, 32'h0D);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        cmp({30'h0, charge_pump_on, seq_busy}, 32'h1);
        @(posedge clock);
        stop_mode <= 1'b0;
        xfer(1'b0, ar(10'h014), 32'h0);
        cmp({31'h0, slv}, 32'h1);
        wait_idle;
        wr(13'h0000, 32'h00);
        rc(ar(10'h014), 8'h3C);
        // Stop entered only while idle starts nothing
        stop_mode <= 1'b1;
        repeat (2) @(posedge clock);
        stop_mode <= 1'b0;
        cmp({31'h0, seq_busy}, 32'h0);
        // Full block protection, then security
        op(2'h1, 10'h200, 8'h00);
        rc(ar(10'h200), 8'hFF);
        do_reset;
        set_div;
        rc(13'h0004, 8'hFF);
        op(2'h0, 10'h003, 8'h00);
        rc(ar(10'h003), 8'hFF);
        op(2'h0, 10'h1FF, 8'h00);
        rc(ar(10'h1FF), 8'hFF);
        op(2'h0, 10'h200, 8'hE0);
        rc(ar(10'h200), 8'hE0);
        do_reset;
        set_div;
        rc(13'h0004, 8'hE0);
        op(2'h0, 10'h003, 8'h00);
        rc(ar(10'h003), 8'h00);
        op(2'h2, 10'h003, 8'h00);
        rc(ar(10'h003), 8'h00);
        op(2'h1, 10'h003, 8'h00);
        rc(ar(10'h003), 8'hFF);
        op(2'h0, 10'h0F5, 8'h00);
        rc(ar(10'h0F5), 8'hFF);
        op(2'h1, 10'h200, 8'h00);
        rc(ar(10'h200), 8'hE0);
        wr(13'h0004, 32'h10);
        rc(13'h0004, 8'h00);
        // Divider lock, made permanent through the stored byte
        op(2'h0, 10'h201, 8'h7F);
        rc(ar(10'h201), 8'h7F);
        wr(13'h0008, 32'h00);
        wr(13'h000C, 32'h09);
        rc(13'h000C, 8'h04);
        wr(13'h0008, 32'h80);
        rc(13'h0008, 8'h00);
        op(2'h0, 10'h202, 8'h00);
        rc(ar(10'h202), 8'hFF);
        do_reset;
        rc(13'h0008, 8'h07);
        rc(13'h000C, 8'hFF);
        conclude;
    end
endmodule // tb_eep_ctrl

bind eep_ctrl eep_ctrl_chk eep_ctrl_chk_inst
(
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .charge_pump_on(charge_pump_on), .seq_busy(seq_busy),
    .array_powered(array_powered)
);
`default_nettype wire
